// File: design/gmcr_rx.sv
`timescale 1ns/10ps
// Operation
// - Both MX and MR high means idle; slot data is ignored then.
// - Any idle pattern is accepted; idle is known from handshake bits only.
// - First byte with MX low, seen twice, is latched; read then MR low next frame.
// - Next byte marked by one frame MX high; seen twice, latched; read then MR pulse.
// - MX high two frames running returns to idle with MR high, byte dropped.
// - MX and MR both low means both ends are active mid-message.
// - MX low, MR high once means first byte received, not acknowledged.
// - MX low with MR held high repeatedly means receiver terminates.
// - Abort is MR high at least two consecutive frames, then idle.
// - As master, a slave abort sets a host-readable abort flag.
// - The abort flag clears on a host write of the transmit byte, unless an abort is seen in that same cycle.
// - The receiver never starts an abort of an incoming message.
module gmcr_rx
	import gmcr_pkg::*;
(
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	input  wire logic         i_frame,
	input  wire gmcr_slot_s   i_rx_slot,
	input  wire logic         i_dll_en,
	input  wire logic         i_rx_read,
	input  wire logic         i_master,
	input  wire logic         i_tx_active,
	input  wire logic         i_tx_mr_in,
	input  wire logic         i_tx_write,
	output logic              o_mr,
	output gmcr_status_s      o_status
);

	gmcr_state_e state;
	gmcr_state_e next_state;
	logic        prev_mx;
	logic [7:0]  prev_data;
	logic        have_prev;
	logic        next_mr;
	logic        rx_ready;
	logic [7:0]  rx_byte;
	logic        slave_abort;
	logic        latch_byte;
	logic        read_seen;
	logic        rx_byte_is_later;

	wire         mx = i_rx_slot.mx;
	wire [7:0]   data = i_rx_slot.data;
	// Two identical receptions, or one if double look is off.
	wire         same_twice = have_prev && (prev_data == data);
	wire         byte_ok = i_dll_en ? same_twice : 1'b1;
	// MX high in this frame and the last one is the end of message.
	wire         mx_end = mx && prev_mx;
	wire         host_rd = i_rx_read && rx_ready;

	// Next-state decode; its result is taken into the state only at a frame boundary.
	always_comb begin
		next_state = state;
		next_mr    = o_mr;
		latch_byte = 1'b0;
		case (state)
			GMCR_IDLE: begin
				// Data while MX and MR are high is not looked at.
				next_mr = 1'b1;
				// Single look takes the first MX-low byte at once.
				if (!mx && !i_dll_en) begin
					latch_byte = 1'b1;
					next_state = GMCR_WAIT_READ;
				end else if (!mx) begin
					next_state = GMCR_FIRST;
				end
			end
			GMCR_FIRST: begin
				// MR stays high while the first byte is unacknowledged.
				if (mx) begin
					next_state = GMCR_IDLE;
				end else if (byte_ok) begin
					latch_byte = 1'b1;
					next_state = GMCR_WAIT_READ;
				end
			end
			GMCR_WAIT_READ: begin
				// Waiting on the host: hold the handshake, never abort.
				if (mx_end) begin
					next_state = GMCR_IDLE;
					next_mr    = 1'b1;
				end else if (read_seen) begin
					next_state = GMCR_ACK_PEND;
					next_mr    = 1'b0;
				end
			end
			GMCR_ACK_PEND: begin
				// Acknowledge went out; after a later byte the one-frame MR pulse is now done.
				// MR falls back so the pulse is not read as a termination.
				next_mr    = 1'b0;
				next_state = GMCR_ACTIVE;
				if (mx) begin
					next_state = GMCR_NEXT;
				end
			end
			GMCR_ACTIVE: begin
				if (mx) begin
					next_state = GMCR_NEXT;
				end
			end
			GMCR_NEXT: begin
				if (mx_end) begin
					next_state = GMCR_IDLE;
					next_mr    = 1'b1;
				end else if (byte_ok) begin
					latch_byte = 1'b1;
					next_state = GMCR_WAIT_READ;
				end
			end
			default: begin
				next_state = GMCR_IDLE;
				next_mr    = 1'b1;
			end
		endcase
	end

	// Acknowledge of later bytes is a single-frame MR high pulse.
	wire ack_pulse = (state == GMCR_WAIT_READ) && read_seen && !mx_end
		&& (rx_byte_is_later);
	wire  mr_frame = ack_pulse ? 1'b1 : next_mr;

	// State and handshake advance once per frame.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state     <= GMCR_IDLE;
			o_mr      <= MR_IDLE;
			prev_mx   <= 1'b1;
			prev_data <= IDLE_BYTE;
			have_prev <= 1'b0;
		end else if (i_frame) begin
			state     <= next_state;
			o_mr      <= mr_frame;
			prev_mx   <= mx;
			prev_data <= data;
			have_prev <= !mx || (state != GMCR_IDLE);
		end
	end

	// Remembers whether the latched byte is the first of a message.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_byte_is_later <= 1'b0;
		end else if (i_frame && latch_byte) begin
			rx_byte_is_later <= (state == GMCR_NEXT);
		end
	end

	// Ready flag: a new latch wins over a host read in the same cycle.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_ready  <= 1'b0;
			rx_byte   <= IDLE_BYTE;
			read_seen <= 1'b0;
		end else begin
			if (i_frame && latch_byte) begin
				rx_ready <= 1'b1;
				rx_byte  <= data;
			end else if (host_rd) begin
				rx_ready <= 1'b0;
			end
			if (i_frame && latch_byte) begin
				read_seen <= 1'b0;
			end else if (host_rd) begin
				read_seen <= 1'b1;
			end
		end
	end

	// Abort monitoring for the transmit direction when acting as master.
	gmcr_abort_det u_abort (
		.i_core_clk         (i_core_clk),
		.i_rst              (i_rst),
		.i_frame            (i_frame),
		.i_master           (i_master),
		.i_tx_active        (i_tx_active),
		.i_mr_in            (i_tx_mr_in),
		.i_tx_write         (i_tx_write),
		.o_slave_abort_flag (slave_abort)
	);

	// Status view registered so the outputs come from flip-flops.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_status <= '0;
		end else begin
			o_status.rx_ready    <= rx_ready;
			o_status.slave_abort <= slave_abort;
			o_status.rx_byte     <= rx_byte;
		end
	end

	// Two MX-high frames in a row while a byte is pending or arriving.
	sequence s_mx_end_seen;
		i_frame && mx_end && (state inside {GMCR_NEXT, GMCR_WAIT_READ});
	endsequence

	// Channel back in idle with the acknowledge bit released high.
	sequence s_back_idle;
		(state == GMCR_IDLE) && o_mr;
	endsequence

	chk_idle_mr_high: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state == GMCR_IDLE) |-> o_mr)
		else $error("MR low while idle");

	chk_end_to_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_mx_end_seen |=> s_back_idle)
		else $error("double MX high did not return to idle");

	chk_first_latch: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_frame && state == GMCR_FIRST && !mx && byte_ok)
		|=> rx_ready && (rx_byte == $past(data)))
		else $error("first byte not latched");

	chk_no_ack_unread: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state == GMCR_WAIT_READ && !read_seen && i_frame && !mx_end)
		|=> $stable(o_mr))
		else $error("acknowledge before host read");

	chk_ack_after_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_frame && state == GMCR_WAIT_READ && read_seen && !mx_end && !rx_byte_is_later)
		|=> !o_mr)
		else $error("first acknowledge not driven low");

	chk_later_ack_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_frame && state == GMCR_WAIT_READ && read_seen && !mx_end && rx_byte_is_later)
		|=> o_mr && state == GMCR_ACK_PEND)
		else $error("later acknowledge pulse missing");

	chk_dll_off_latch: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_frame && !i_dll_en && state == GMCR_NEXT && !mx_end)
		|=> rx_ready)
		else $error("single look did not latch");

	chk_ready_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(host_rd && !(i_frame && latch_byte)) |=> !rx_ready ##1 !o_status.rx_ready)
		else $error("ready flag not cleared by read");

endmodule : gmcr_rx

// File: design/gmcr_pkg.sv
package gmcr_pkg;

	// Monitor byte width and idle pattern.
	localparam int unsigned   BYTE_W      = 8;
	localparam logic [7:0]    IDLE_BYTE   = 8'hFF;
	// Frame period and core clock period, both in ns.
	localparam int unsigned   FRAME_NS    = 125000;
	localparam int unsigned   CLK_NS      = 100;
	localparam int unsigned   FRAME_CYC   = FRAME_NS / CLK_NS;
	// Abort is signalled by MR high for at least this many frames.
	localparam int unsigned   ABORT_FRAMES = 2;
	// Reset level of the outgoing acknowledge bit.
	localparam logic          MR_IDLE     = 1'b1;

	// Receiver states.
	typedef enum logic [2:0] {
		GMCR_IDLE,
		GMCR_FIRST,
		GMCR_WAIT_READ,
		GMCR_ACK_PEND,
		GMCR_ACTIVE,
		GMCR_NEXT
	} gmcr_state_e;

	// One monitor slot as seen on the serial link each frame.
	typedef struct packed {
		logic       mx;
		logic [7:0] data;
	} gmcr_slot_s;

	// Host-side status view.
	typedef struct packed {
		logic       rx_ready;
		logic       slave_abort;
		logic [7:0] rx_byte;
	} gmcr_status_s;

endpackage : gmcr_pkg

// File: design/gmcr_abort_det.sv
`timescale 1ns/10ps
// Watches the incoming MR bit while this end transmits as master and
// flags a slave abort once MR has stayed high for the abort run length.
module gmcr_abort_det
	import gmcr_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_frame,
	input  wire logic i_master,
	input  wire logic i_tx_active,
	input  wire logic i_mr_in,
	input  wire logic i_tx_write,
	output logic      o_slave_abort_flag
);

	logic [1:0] high_run;
	wire        abort_seen;
	logic       mr_high_last;
	logic       mr_high_before;

	// Abort needs two consecutive frames of MR high while we are mid-message.
	assign abort_seen = i_frame && i_master && i_tx_active && i_mr_in
		&& (high_run == 2'(ABORT_FRAMES - 1));

	// Run counter saturates; it restarts whenever MR drops.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			high_run <= 2'h0;
		end else if (i_frame) begin
			if (!i_mr_in || !i_tx_active) begin
				high_run <= 2'h0;
			end else if (high_run != 2'h3) begin
				high_run <= high_run + 2'h1;
			end
		end
	end

	// Set wins over the clear so an abort in the write cycle is kept.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_slave_abort_flag <= 1'b0;
		end else if (abort_seen) begin
			o_slave_abort_flag <= 1'b1;
		end else if (i_tx_write) begin
			o_slave_abort_flag <= 1'b0;
		end
	end

	// MR history of the last two frames for the checks only; it is kept
	// apart from the run counter so a counter fault cannot hide itself.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			mr_high_last   <= 1'b0;
			mr_high_before <= 1'b0;
		end else if (i_frame) begin
			mr_high_last   <= i_mr_in && i_tx_active;
			mr_high_before <= mr_high_last;
		end
	end

	chk_abort_clear_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_tx_write && !abort_seen) |=> !o_slave_abort_flag)
		else $error("abort flag not cleared by transmit write");

	chk_abort_two_frames: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_frame && i_master && i_tx_active && i_mr_in && mr_high_last && !mr_high_before)
		|=> o_slave_abort_flag)
		else $error("abort run not flagged");

endmodule : gmcr_abort_det

// File: verification/gmcr_tx_model.sv
`timescale 1ns/10ps
// Far-side GCI transmitter: frames the monitor slot and drives MX, byte and MR.
module gmcr_tx_model
	import gmcr_pkg::*;
#(
	parameter int GAP = 16
)(
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	input  wire logic       i_mx,
	input  wire logic [7:0] i_data,
	input  wire logic       i_mr,
	output logic            o_frame,
	output gmcr_slot_s      o_slot,
	output logic            o_mr
);
	int cnt;

	// Off-slot the lines toggle every cycle, so a receiver that samples
	// outside the frame strobe cannot pass by luck.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt     <= 0;
			o_frame <= 1'b0;
			o_slot  <= {1'b1, IDLE_BYTE};
			o_mr    <= 1'b1;
		end else begin
			cnt     <= (cnt == GAP - 1) ? 0 : cnt + 1;
			o_frame <= (cnt == GAP - 1);
			if (cnt == GAP - 1) begin
				o_slot <= {i_mx, i_data};
				o_mr   <= i_mr;
			end else begin
				o_slot <= ~o_slot;
				o_mr   <= ~o_mr;
			end
		end
	end
endmodule : gmcr_tx_model

// File: verification/gmcr_rx_tb.sv
`timescale 1ns/10ps
module gmcr_rx_tb;
	import gmcr_pkg::*;

	logic         clk, rst, frm, dll, rd, master, txa, txw, mr_in, t_mx, t_mr, o_mr, rdy_q;
	logic [7:0]   t_data, a;
	gmcr_slot_s   slot;
	gmcr_status_s st;
	logic [7:0]   exp_q[$];
	int           n_mismatch, num_checks, seed;

	gmcr_tx_model tx_u (.i_core_clk(clk), .i_rst(rst), .i_mx(t_mx), .i_data(t_data),
		.i_mr(t_mr), .o_frame(frm), .o_slot(slot), .o_mr(mr_in));
	gmcr_rx dut_u (.i_core_clk(clk), .i_rst(rst), .i_frame(frm), .i_rx_slot(slot),
		.i_dll_en(dll), .i_rx_read(rd), .i_master(master), .i_tx_active(txa),
		.i_tx_mr_in(mr_in), .i_tx_write(txw), .o_mr(o_mr), .o_status(st));

	task automatic miss(input string m);
		n_mismatch++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : miss

	task automatic chk_bit(input logic act, input logic exp, input string m);
		num_checks++;
		if (act !== exp) miss(m);
	endtask : chk_bit

	task automatic chk_byte(input logic [7:0] act, input logic [7:0] exp);
		num_checks++;
		if (act !== exp) miss("latched byte differs");
	endtask : chk_byte

	task automatic finish_test();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	// Present one slot and return just after the edge that samples it.
	task automatic frame(input logic mx, input logic [7:0] d, input logic mr);
		@(posedge clk);
		t_mx   <= mx;
		t_data <= d;
		t_mr   <= mr;
		@(posedge clk iff frm);
		#1;
	endtask : frame

	// Host read of the received byte; the ready flag must then drop.
	task automatic rd_byte();
		repeat (3) @(posedge clk);
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk_bit(st.rx_ready, 1'b0, "ready not cleared");
	endtask : rd_byte

	// Each rising ready flag consumes the oldest expected byte; extra ones are faults.
	always @(posedge clk) begin
		rdy_q <= st.rx_ready;
		if (st.rx_ready === 1'b1 && rdy_q !== 1'b1) begin
			if (exp_q.size() == 0) miss("unexpected byte latched");
			else chk_byte(st.rx_byte, exp_q.pop_front());
		end
	end

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// A full run is well under a hundred frames of sixteen cycles.
	initial begin
		#2000000;
		miss("timeout");
		finish_test();
	end

	initial begin
		{rst, t_mx, t_mr, dll} = 4'hF;
		{rd, master, txa, txw} = 4'h0;
		t_data = IDLE_BYTE;
		seed = 2635;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// Idle with random patterns: nothing may be latched.
		repeat (3) begin
			frame(1'b1, 8'($random(seed)), 1'b1);
			chk_bit(o_mr, 1'b1, "mr left idle");
		end
		// First byte seen twice; acknowledge only follows the read.
		a = 8'($random(seed));
		exp_q.push_back(a);
		frame(1'b0, a, 1'b1);
		frame(1'b0, a, 1'b1);
		chk_bit(o_mr, 1'b1, "ack before read");
		frame(1'b0, a, 1'b1);
		chk_bit(o_mr, 1'b1, "ack before read");
		rd_byte();
		frame(1'b0, a, 1'b1);
		chk_bit(o_mr, 1'b0, "first ack missing");
		// Next byte marked by one frame of MX high, then a one-frame MR pulse.
		a = 8'($random(seed));
		exp_q.push_back(a);
		frame(1'b1, a, 1'b1);
		frame(1'b0, a, 1'b1);
		chk_bit(o_mr, 1'b0, "mr rose early");
		rd_byte();
		frame(1'b0, a, 1'b1);
		chk_bit(o_mr, 1'b1, "ack pulse missing");
		frame(1'b0, a, 1'b1);
		chk_bit(o_mr, 1'b0, "ack pulse too long");
		// MX held high ends the message and drops the byte in the slot.
		frame(1'b1, 8'($random(seed)), 1'b1);
		chk_bit(o_mr, 1'b0, "receiver aborted");
		frame(1'b1, 8'($random(seed)), 1'b1);
		chk_bit(o_mr, 1'b1, "no return to idle");
		// Single look latches on the first reception, first and later byte.
		@(posedge clk);
		dll <= 1'b0;
		a = 8'($random(seed));
		exp_q.push_back(a);
		frame(1'b0, a, 1'b1);
		rd_byte();
		frame(1'b0, a, 1'b1);
		chk_bit(o_mr, 1'b0, "single look ack");
		// The marker frame carries other data, so only a single look can latch.
		a = 8'($random(seed));
		exp_q.push_back(a);
		frame(1'b1, ~a, 1'b1);
		frame(1'b0, a, 1'b1);
		rd_byte();
		frame(1'b0, a, 1'b1);
		chk_bit(o_mr, 1'b1, "single look ack pulse");
		frame(1'b1, IDLE_BYTE, 1'b1);
		frame(1'b1, IDLE_BYTE, 1'b1);
		chk_bit(o_mr, 1'b1, "no return to idle");
		// Slave abort: MR high two frames running while we transmit as master.
		@(posedge clk);
		master <= 1'b1;
		txa    <= 1'b1;
		frame(1'b1, IDLE_BYTE, 1'b0);
		frame(1'b1, IDLE_BYTE, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk_bit(st.slave_abort, 1'b0, "abort after one frame");
		frame(1'b1, IDLE_BYTE, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk_bit(st.slave_abort, 1'b1, "abort not flagged");
		@(posedge clk);
		txw <= 1'b1;
		@(posedge clk);
		txw <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk_bit(st.slave_abort, 1'b0, "abort not cleared");
		chk_bit(exp_q.size() == 0, 1'b1, "byte never latched");
		finish_test();
	end
endmodule : gmcr_rx_tb
